// ==== logic/ecwd_pkg.sv ====
// constants shared by the embedded-controller watchdog design files
package ecwd_pkg;

  localparam int unsigned ADDR_W           = 32;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned CNT_W            = 16;

  // register map, byte addresses in the controller's internal space
  localparam logic [31:0] WD_BASE_ADDR     = 32'h0000_0400;
  localparam logic [31:0] OFS_RELOAD_VALUE = 32'h0000_0000;
  localparam logic [31:0] OFS_CONTROL      = 32'h0000_0004;
  localparam logic [31:0] OFS_SERVICE      = 32'h0000_0008;
  localparam logic [31:0] OFS_COUNT        = 32'h0000_000C;

  // control register fields
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_FLAG_BIT    = 1;
  localparam int unsigned CTRL_STALL_LSB   = 2;
  localparam int unsigned STALL_W          = 3;

  // values after reset
  localparam logic [15:0] RELOAD_RST       = 16'h000F;
  localparam logic [15:0] COUNT_RST        = 16'h000F;
  localparam logic [2:0]  STALL_EN_RST     = 3'h0;
  localparam logic        ENABLE_RST       = 1'b0;
  localparam logic        FLAG_RST         = 1'b0;

  // timing
  localparam int unsigned REF_CLK_HZ       = 10_000_000;
  localparam int unsigned REF_CLK_NS       = 100;
  localparam int unsigned SLOW_TICK_HZ     = 32_768;
  localparam int unsigned SLOW_TICK_CYC    = REF_CLK_HZ / SLOW_TICK_HZ;
  localparam int unsigned TICKS_PER_DEC    = 33;

endpackage : ecwd_pkg

// ==== logic/ecwd_tick_div.sv ====
// divider that makes the one-cycle slow tick enable from the reference clock
module ecwd_tick_div #(
  parameter int unsigned DIV = ecwd_pkg::SLOW_TICK_CYC
) (
  input  wire logic ref_clk,  // reference clock
  input  wire logic rst_n,    // synchronised reset, active low
  output logic      tick_q    // one-cycle slow tick enable
);
  import ecwd_pkg::*;

  localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  if (DIV < 2)
  begin : g_div_chk
    $error("ecwd_tick_div: DIV must be at least 2");
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          tick_d;

  always_comb
  begin
    tick_d = 1'b0;
    cnt_d  = cnt_q + CW'(1);
    if (cnt_q == LAST)
    begin
      cnt_d  = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

endmodule : ecwd_tick_div

// ==== logic/ecwd_watchdog.sv ====
// watchdog timer top: register port, slow-tick counter, underflow event
// Operation
// - counter logic advances only on slow tick
// - power-on reset restores every default
// - expiry emits one event pulse
// - event condition held until power-on reset
// - enabling starts the counter decrementing
// - clearing enable stops and gates counting
// - underflow fires event and sets flag
// - reload on load write, kick, event
// - each decrement takes 33 slow ticks
// - 16-bit reload register, default Fh, reloads
// - control bits 4..2 enable stall inputs
// - enabled active stall holds the count
// - control bit 1 flags underflow reset
// - writing one clears flag, zero ignored
// - control bit 0 enables, reset disabled
// - four registers at 400h plus 0..Ch
// - kick write reloads if enabled, reads zero
// - count register reads live counter value
module ecwd_watchdog #(
  parameter int unsigned TICK_DIV  = ecwd_pkg::SLOW_TICK_CYC,
  parameter int unsigned DEC_TICKS = ecwd_pkg::TICKS_PER_DEC
) (
  input  wire logic                        ref_clk,          // 10 MHz reference clock
  input  wire logic                        rstn,             // power-on reset, active low
  input  wire logic [ecwd_pkg::ADDR_W-1:0] reg_addr,         // register byte address
  input  wire logic [ecwd_pkg::DATA_W-1:0] reg_wdata,        // write data
  input  wire logic                        reg_wr,           // write strobe, one cycle
  input  wire logic                        reg_rd,           // read strobe, one cycle
  input  wire logic [ecwd_pkg::STALL_W-1:0] stall_inputs,    // stall requests, active high
  output logic      [ecwd_pkg::DATA_W-1:0] reg_rdata_q,      // read data
  output logic                             reg_rvalid_q,     // read data valid pulse
  output logic                             watchdog_event_q, // expiry pulse
  output logic                             event_latched_q   // expiry seen since reset
);
  import ecwd_pkg::*;

  localparam int unsigned PW = (DEC_TICKS > 1) ? $clog2(DEC_TICKS) : 1;
  localparam logic [PW-1:0] PRE_LAST = PW'(DEC_TICKS - 1);

  if (DEC_TICKS < 2)
  begin : g_dec_chk
    $error("ecwd_watchdog: DEC_TICKS must be at least 2");
  end

  if (TICK_DIV < 2)
  begin : g_div_chk
    $error("ecwd_watchdog: TICK_DIV must be at least 2");
  end

  if (DATA_W < CNT_W)
  begin : g_width_chk
    $error("ecwd_watchdog: data word narrower than the counter");
  end

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
    addr_hit = (a == (WD_BASE_ADDR + ofs));
  endfunction : addr_hit

  // reset release through two flops; assertion stays asynchronous
  logic rst_meta_q;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  logic tick;

  // slow tick as an enable pulse keeps a single clock in the design
  ecwd_tick_div #(
    .DIV (TICK_DIV)
  ) u_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .tick_q  (tick)
  );

  logic [CNT_W-1:0]   reload_q;
  logic [CNT_W-1:0]   reload_d;
  logic [STALL_W-1:0] stall_en_q;
  logic [STALL_W-1:0] stall_en_d;
  logic               enable_q;
  logic               enable_d;
  logic               flag_q;
  logic               flag_d;
  logic               load_pend_q;
  logic               load_pend_d;
  logic               kick_pend_q;
  logic               kick_pend_d;
  logic               run_q;
  logic               run_d;
  logic [CNT_W-1:0]   count_q;
  logic [CNT_W-1:0]   count_d;
  logic [PW-1:0]      pre_q;
  logic [PW-1:0]      pre_d;
  logic               underflow;
  logic               event_d;
  logic               latched_d;
  logic [DATA_W-1:0]  rdata_d;
  logic               rvalid_d;
  logic               stalled;
  logic               reload_now;
  logic               wr_reload;
  logic               wr_ctrl;
  logic               wr_kick;

  assign wr_reload  = reg_wr && addr_hit(reg_addr, OFS_RELOAD_VALUE);
  assign wr_ctrl    = reg_wr && addr_hit(reg_addr, OFS_CONTROL);
  assign wr_kick    = reg_wr && addr_hit(reg_addr, OFS_SERVICE);
  // a stall needs both its input and its enable bit
  assign stalled    = |(stall_inputs & stall_en_q);
  // a kick while disabled is dropped at the tick instead of lingering for a later enable
  assign reload_now = load_pend_q || (kick_pend_q && enable_q);

  // register group: bus writes land at once, the counter sees them at the next tick
  always_comb
  begin
    reload_d   = reload_q;
    stall_en_d = stall_en_q;
    enable_d   = enable_q;
    flag_d     = flag_q;
    if (wr_reload)
    begin
      reload_d = reg_wdata[CNT_W-1:0];
    end
    // reserved control bits are dropped here and read back as zero
    if (wr_ctrl)
    begin
      stall_en_d = reg_wdata[CTRL_STALL_LSB +: STALL_W];
      enable_d   = reg_wdata[CTRL_ENABLE_BIT];
      if (reg_wdata[CTRL_FLAG_BIT])
      begin
        flag_d = 1'b0;
      end
    end
    // set after clear: an underflow in the clearing cycle is not lost
    if (underflow)
    begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reload_q   <= RELOAD_RST;
      stall_en_q <= STALL_EN_RST;
      enable_q   <= ENABLE_RST;
      flag_q     <= FLAG_RST;
    end
    else
    begin
      reload_q   <= reload_d;
      stall_en_q <= stall_en_d;
      enable_q   <= enable_d;
      flag_q     <= flag_d;
    end
  end

  // hand-over group: bus requests wait here for the next slow tick
  always_comb
  begin
    load_pend_d = load_pend_q || wr_reload;
    kick_pend_d = kick_pend_q || wr_kick;
    run_d       = run_q;
    if (tick)
    begin
      // requests are consumed now; a write in this same cycle stays pending
      load_pend_d = wr_reload;
      kick_pend_d = wr_kick;
      run_d       = enable_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_pend_q <= 1'b0;
      kick_pend_q <= 1'b0;
      run_q       <= 1'b0;
    end
    else
    begin
      load_pend_q <= load_pend_d;
      kick_pend_q <= kick_pend_d;
      run_q       <= run_d;
    end
  end

  // counter group: acts only on slow ticks, so one clock serves both rates
  always_comb
  begin
    count_d   = count_q;
    pre_d     = pre_q;
    underflow = 1'b0;
    event_d   = 1'b0;
    latched_d = event_latched_q;
    if (tick)
    begin
      if (reload_now)
      begin
        count_d = reload_q;
        pre_d   = '0;
      end
      else if (run_q && enable_q && !stalled)
      begin
        if (pre_q == PRE_LAST)
        begin
          pre_d = '0;
          // underflow reloads at once so the next interval starts without a gap
          if (count_q == '0)
          begin
            underflow = 1'b1;
            count_d   = reload_q;
          end
          else
          begin
            count_d = count_q - CNT_W'(1);
          end
        end
        else
        begin
          pre_d = pre_q + PW'(1);
        end
      end
      // disabled or stalled: prescaler and count frozen, nothing toggles
    end
    if (underflow)
    begin
      event_d   = 1'b1;
      latched_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q          <= COUNT_RST;
      pre_q            <= '0;
      watchdog_event_q <= 1'b0;
      event_latched_q  <= 1'b0;
    end
    else
    begin
      count_q          <= count_d;
      pre_q            <= pre_d;
      watchdog_event_q <= event_d;
      event_latched_q  <= latched_d;
    end
  end

  // read port: only a read strobe updates the data word, so it holds between reads
  always_comb
  begin
    rdata_d  = reg_rdata_q;
    rvalid_d = reg_rd;
    if (reg_rd)
    begin
      rdata_d = '0;
      if (addr_hit(reg_addr, OFS_RELOAD_VALUE))
      begin
        rdata_d[CNT_W-1:0] = reload_q;
      end
      else if (addr_hit(reg_addr, OFS_CONTROL))
      begin
        rdata_d[CTRL_STALL_LSB +: STALL_W] = stall_en_q;
        rdata_d[CTRL_FLAG_BIT]             = flag_q;
        rdata_d[CTRL_ENABLE_BIT]           = enable_q;
      end
      else if (addr_hit(reg_addr, OFS_COUNT))
      begin
        rdata_d[CNT_W-1:0] = count_q;
      end
      // kick, reserved bits and unmapped addresses read as zero
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q  <= '0;
      reg_rvalid_q <= 1'b0;
    end
    else
    begin
      reg_rdata_q  <= rdata_d;
      reg_rvalid_q <= rvalid_d;
    end
  end

endmodule : ecwd_watchdog

// ==== tb/ecwd_watchdog_asserts.sv ====
// port-level assertions for the watchdog top
module ecwd_watchdog_asserts (
  input wire logic                        ref_clk,          // clock
  input wire logic                        rstn,             // reset, active low
  input wire logic [ecwd_pkg::ADDR_W-1:0] reg_addr,         // byte address
  input wire logic                        reg_rd,           // read strobe
  input wire logic [ecwd_pkg::DATA_W-1:0] reg_rdata_q,      // read data
  input wire logic                        reg_rvalid_q,     // read valid
  input wire logic                        watchdog_event_q, // expiry pulse
  input wire logic                        event_latched_q   // held event
);
  import ecwd_pkg::*;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  property p_rvalid; reg_rd |=> reg_rvalid_q; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid missing");
  property p_rdhold; !reg_rd |=> $stable(reg_rdata_q); endproperty
  a_rdhold: assert property (p_rdhold) else $error("read data moved");
  property p_pulse; watchdog_event_q |=> !watchdog_event_q; endproperty
  a_pulse: assert property (p_pulse) else $error("event longer than a cycle");
  property p_latch; watchdog_event_q |-> ##[0:1] event_latched_q; endproperty
  a_latch: assert property (p_latch) else $error("event not latched");
  property p_hold; event_latched_q |=> event_latched_q; endproperty
  a_hold: assert property (p_hold) else $error("latched event dropped");
  property p_kick; reg_rd && reg_addr == 32'h0000_0408 |=> reg_rdata_q == 32'h0; endproperty
  a_kick: assert property (p_kick) else $error("kick read not zero");
  property p_ctrl; reg_rd && reg_addr == 32'h0000_0404 |=> reg_rdata_q[31:5] == 27'h0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("control spare bits set");
  property p_cnt; reg_rd && reg_addr == 32'h0000_040C |=> reg_rdata_q[31:16] == 16'h0; endproperty
  a_cnt: assert property (p_cnt) else $error("count upper bits set");
  property p_unmap; reg_rd && reg_addr[31:4] != 28'h0000_040 |=> reg_rdata_q == 32'h0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  c_event: cover property (watchdog_event_q);
  c_kick: cover property (reg_rd && reg_addr == 32'h0000_0408);
  c_unmap: cover property (reg_rd && reg_addr[31:4] != 28'h0000_040);
endmodule : ecwd_watchdog_asserts

bind ecwd_watchdog ecwd_watchdog_asserts ecwd_watchdog_asserts_i (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
  .watchdog_event_q(watchdog_event_q), .event_latched_q(event_latched_q));

// ==== tb/tb_ecwd_watchdog.sv ====
// self-checking bench for the watchdog top
module tb_ecwd_watchdog;
  timeunit 1ns;
  timeprecision 1ns;
  import ecwd_pkg::*;
  localparam int unsigned TD = 2;
  localparam int unsigned DT = 2;
  logic        ref_clk, rstn, reg_wr, reg_rd, reg_rvalid_q, watchdog_event_q, event_latched_q;
  logic [31:0] reg_addr, reg_wdata, reg_rdata_q, got;
  logic [2:0]  stall_inputs;
  logic [15:0] rnd;
  int          num_errors, n_tests, ev_cnt, c;
  ecwd_watchdog #(.TICK_DIV(TD), .DEC_TICKS(DT)) ecwd_watchdog_i (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .stall_inputs(stall_inputs), .reg_rdata_q(reg_rdata_q), .reg_rvalid_q(reg_rvalid_q),
    .watchdog_event_q(watchdog_event_q), .event_latched_q(event_latched_q));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [31:0] ctl(input logic en, input logic [2:0] st, input logic fl);
    return {27'h0, st, fl, en};
  endfunction : ctl
  // window allows for the two-tick hand-over into the counter domain
  function automatic logic [31:0] in_win(input int n, input int cy);
    return {31'h0, cy >= (n + 1) * DT * TD - TD && cy <= (n + 3) * DT * TD + 8};
  endfunction : in_win
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [31:0] off, input logic [31:0] d);
    @(negedge ref_clk);
    reg_addr  = WD_BASE_ADDR + off;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge ref_clk);
    reg_wr    = 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] off, input logic [31:0] e, input logic [31:0] m);
    @(negedge ref_clk);
    reg_addr = WD_BASE_ADDR + off;
    reg_rd   = 1'b1;
    @(negedge ref_clk);
    reg_rd   = 1'b0;
    got      = reg_rdata_q;
    chk("read valid", {31'h0, reg_rvalid_q}, 32'h1);
    chk($sformatf("register %h", off), got & m, e & m);
  endtask : rd
  task automatic wait_ev(input int lim);
    int ev0;
    ev0 = ev_cnt;
    c   = 0;
    while (ev_cnt == ev0 && c < lim)
    begin
      @(negedge ref_clk);
      c++;
    end
  endtask : wait_ev
  task automatic do_reset();
    rstn = 1'b0;
    // count rising edges: the clock's first step from unknown can look like a falling edge
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
  endtask : do_reset
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
    if (watchdog_event_q === 1'b1)
      ev_cnt++;
  initial
  begin
    #(100 * 20000);
    num_errors++;
    final_report();
  end
  initial
  begin
    {reg_wr, reg_rd, reg_addr, reg_wdata, stall_inputs} = '0;
    {num_errors, n_tests, ev_cnt} = '0;
    rnd = 16'h1E93;
    do_reset();
    rd(32'h0, 32'hF, '1);
    rd(32'h4, 32'h0, '1);
    rd(32'h8, 32'h0, '1);
    rd(32'hC, 32'hF, '1);
    rd(32'h10, 32'h0, '1);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      stall_inputs = rnd[2:0];
      wr(32'h0, {~rnd, rnd});
      rd(32'h0, {16'h0, rnd}, '1);
      wr(32'hC, {rnd, ~rnd});
      repeat (20) @(negedge ref_clk);
      rd(32'hC, {16'h0, rnd}, '1);
    end
    for (int k = 0; k < 8; k++)
    begin
      wr(32'h4, {24'h0, 3'h7, 3'(k), 2'b00});
      rd(32'h4, ctl(1'b0, 3'(k), 1'b0), '1);
    end
    stall_inputs = 3'h7;
    wr(32'h0, 32'h5);
    for (int k = 0; k < 3; k++)
    begin
      wr(32'h4, ctl(1'b1, 3'(1 << k), 1'b0));
      repeat (60) @(negedge ref_clk);
      rd(32'hC, 32'h5, '1);
    end
    chk("no event while stalled", ev_cnt, 0);
    wr(32'h4, ctl(1'b1, 3'h0, 1'b0));
    wait_ev(200);
    chk("interval", in_win(5, c), 32'h1);
    chk("latched", {31'h0, event_latched_q}, 32'h1);
    rd(32'h4, ctl(1'b1, 3'h0, 1'b1), '1);
    wr(32'h0, 32'hFFFF);
    repeat (20) @(negedge ref_clk);
    wr(32'h4, ctl(1'b1, 3'h0, 1'b0));
    rd(32'h4, ctl(1'b1, 3'h0, 1'b1), '1);
    wr(32'h4, ctl(1'b0, 3'h0, 1'b1));
    rd(32'h4, 32'h0, '1);
    rd(32'hC, 32'h0, 32'hFFFF_0000);
    chk("count ran before stop", {31'h0, got[15:0] != 16'hFFFF}, 32'h1);
    repeat (30) @(negedge ref_clk);
    rd(32'hC, got, '1);
    wr(32'h8, 32'h0);
    repeat (10) @(negedge ref_clk);
    rd(32'hC, got, '1);
    wr(32'h0, 32'd20);
    wr(32'h4, 32'h1);
    c = ev_cnt;
    repeat (10)
    begin
      repeat (60) @(negedge ref_clk);
      wr(32'h8, {16'h0, lfsr(rnd)});
    end
    chk("kicked no event", ev_cnt, c);
    wait_ev(300);
    chk("kick interval", in_win(20, c + 2), 32'h1);
    do_reset();
    chk("latched after reset", {31'h0, event_latched_q}, 32'h0);
    rd(32'h0, 32'hF, '1);
    rd(32'h4, 32'h0, '1);
    final_report();
  end
endmodule : tb_ecwd_watchdog
